// file: src/gain_ramp_consts.svh
// offsets, field positions, reset values of the gain ramp profile bank
`ifndef GAIN_RAMP_CONSTS_SVH
`define GAIN_RAMP_CONSTS_SVH
`define ADDR_W              8
`define DATA_W              16
`define MEM_WORDS           160
`define OFF_STEP_FIRST      8'h01
`define OFF_STEP_LAST       8'ha0
`define OFF_GAIN_LIMITS     8'ha1
`define OFF_GAIN_STEPS      8'ha2
`define OFF_INDEX_LIMITS    8'ha3
`define OFF_BEGIN_TIME      8'ha4
`define OFF_CONTROL         8'hf0
`define FLD_HI_MSB          15
`define FLD_HI_LSB          8
`define FLD_LO_MSB          7
`define FLD_LO_LSB          0
`define CTRL_WREN_BIT       0
`define RST_START_GAIN      8'h00
`define RST_STOP_GAIN       8'h9f
`define RST_UP_STEP         8'h00
`define RST_DOWN_STEP       8'hff
`define RST_START_INDEX     8'h00
`define RST_STOP_INDEX      8'h9f
`define RST_BEGIN_TIME      16'h0000
`endif

// file: src/gain_ramp_pkg.sv
// types for the gain ramp profile bank
package gain_ramp_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [2:0]
    {
        SEL_NONE = 3'b001,
        SEL_MEM  = 3'b010,
        SEL_REG  = 3'b100
    } sel_t;
endpackage

// file: src/gain_ramp_profile_regs.sv
// register bank for gain step memory and profile 0 ramp parameters
`timescale 1ns/1ps
`include "gain_ramp_consts.svh"
module gain_ramp_profile_regs
    import gain_ramp_pkg::*;
#(
    parameter int ADDR_W    = `ADDR_W,
    parameter int MEM_WORDS = `MEM_WORDS
)
(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire word_t             regWrData,
    input  wire logic              regWrStb,
    input  wire logic              regRdStb,
    output word_t                  regRdData,
    output logic                   gainRampWriteEnable,
    output logic [7:0]             startGain,
    output logic [7:0]             stopGain,
    output logic [7:0]             upStep,
    output logic [7:0]             profile0DownStep,
    output logic [7:0]             startIndex,
    output logic [7:0]             stopIndex,
    output word_t                  beginTime
);
    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    initial
    begin
        if (ADDR_W != `ADDR_W)
            $error("gain_ramp_profile_regs: register map needs an 8-bit word address");
        if (MEM_WORDS != `MEM_WORDS)
            $error("gain_ramp_profile_regs: register map holds exactly 160 step words");
        if (MEM_WORDS > (1 << ADDR_W) - 1)
            $error("gain_ramp_profile_regs: step words do not fit the address space");
    end

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic sel_t decode(input logic [ADDR_W-1:0] a);
        if (a >= `OFF_STEP_FIRST && a <= `OFF_STEP_LAST)
            return SEL_MEM;
        else if ((a >= `OFF_GAIN_LIMITS && a <= `OFF_BEGIN_TIME) || a == `OFF_CONTROL)
            return SEL_REG;
        else
            return SEL_NONE;
    endfunction

    // ----------------------------------------
    // field helpers
    // ----------------------------------------
    // upper byte field of a register word
    function automatic logic [7:0] hiField(input word_t w);
        return w[`FLD_HI_MSB:`FLD_HI_LSB];
    endfunction

    // lower byte field of a register word
    function automatic logic [7:0] loField(input word_t w);
        return w[`FLD_LO_MSB:`FLD_LO_LSB];
    endfunction

    // two byte fields packed into one register word
    function automatic word_t joinFields(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    sel_t              wrSel;
    sel_t              rdSel;
    logic [ADDR_W-1:0] memIdx;
    logic              memWr;
    word_t             memRdData;

    assign wrSel  = decode(regAddr);
    assign rdSel  = wrSel;
    assign memIdx = regAddr - `OFF_STEP_FIRST;

    // write enable gate
    // step memory writes need enable bit
    assign memWr = regWrStb && gainRampWriteEnable && (wrSel == SEL_MEM);

    // ----------------------------------------
    // gain step memory
    // ----------------------------------------
    // word at 1h
    gain_step_memory #(
        .DEPTH (MEM_WORDS),
        .AW    (ADDR_W)
    ) stepMem (
        .sys_clk (sys_clk),
        .wrEn    (memWr),
        .wrIdx   (memIdx),
        .wrData  (regWrData),
        .rdIdx   (memIdx),
        .rdData  (memRdData)
    );

    // ----------------------------------------
    // control register
    // ----------------------------------------
    logic       wren_reg;
    logic       wren_next;
    logic       ctrlWr;

    // control register is always writable
    assign ctrlWr = regWrStb && (regAddr == `OFF_CONTROL);

    always_comb
    begin
        wren_next = wren_reg;
        if (ctrlWr)
            wren_next = regWrData[`CTRL_WREN_BIT];
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            wren_reg <= 1'b0;
        else
            wren_reg <= wren_next;
    end

    // ----------------------------------------
    // profile 0 write decode
    // ----------------------------------------
    logic       profWr;
    logic       limitsWr;
    logic       stepsWr;
    logic       indexWr;
    logic       timeWr;

    assign profWr   = regWrStb && gainRampWriteEnable && (wrSel == SEL_REG);
    // one strobe per profile register
    assign limitsWr = profWr && (regAddr == `OFF_GAIN_LIMITS);
    assign stepsWr  = profWr && (regAddr == `OFF_GAIN_STEPS);
    assign indexWr  = profWr && (regAddr == `OFF_INDEX_LIMITS);
    assign timeWr   = profWr && (regAddr == `OFF_BEGIN_TIME);

    // ----------------------------------------
    // profile 0 registers
    // ----------------------------------------
    logic [7:0] startGain_reg;
    logic [7:0] startGain_next;
    logic [7:0] stopGain_reg;
    logic [7:0] stopGain_next;
    logic [7:0] upStep_reg;
    logic [7:0] upStep_next;
    logic [7:0] downStep_reg;
    logic [7:0] downStep_next;
    logic [7:0] startIdx_reg;
    logic [7:0] startIdx_next;
    logic [7:0] stopIdx_reg;
    logic [7:0] stopIdx_next;
    word_t      beginTime_reg;
    word_t      beginTime_next;

    always_comb
    begin
        // each field holds until rewritten
        startGain_next = startGain_reg;
        stopGain_next  = stopGain_reg;
        upStep_next    = upStep_reg;
        downStep_next  = downStep_reg;
        startIdx_next  = startIdx_reg;
        stopIdx_next   = stopIdx_reg;
        beginTime_next = beginTime_reg;
        if (limitsWr)
        begin
            startGain_next = hiField(regWrData);
            stopGain_next  = loField(regWrData);
        end
        if (stepsWr)
        begin
            upStep_next   = hiField(regWrData);
            downStep_next = loField(regWrData);
        end
        if (indexWr)
        begin
            startIdx_next = hiField(regWrData);
            stopIdx_next  = loField(regWrData);
        end
        if (timeWr)
        begin
            beginTime_next = regWrData;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            startGain_reg <= `RST_START_GAIN;
            stopGain_reg  <= `RST_STOP_GAIN;
            upStep_reg    <= `RST_UP_STEP;
            downStep_reg  <= `RST_DOWN_STEP;
            startIdx_reg  <= `RST_START_INDEX;
            stopIdx_reg   <= `RST_STOP_INDEX;
            beginTime_reg <= `RST_BEGIN_TIME;
        end
        else
        begin
            startGain_reg <= startGain_next;
            stopGain_reg  <= stopGain_next;
            upStep_reg    <= upStep_next;
            downStep_reg  <= downStep_next;
            startIdx_reg  <= startIdx_next;
            stopIdx_reg   <= stopIdx_next;
            beginTime_reg <= beginTime_next;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    word_t      rdData_reg;
    word_t      rdData_next;

    always_comb
    begin
        // unmapped and idle cycles read as zero
        rdData_next = '0;
        if (regRdStb)
        begin
            case (rdSel)
                SEL_MEM:
                    rdData_next = memRdData;
                SEL_REG:
                begin
                    case (regAddr)
                        `OFF_GAIN_LIMITS:  rdData_next = joinFields(startGain_reg, stopGain_reg);
                        `OFF_GAIN_STEPS:   rdData_next = joinFields(upStep_reg, downStep_reg);
                        `OFF_INDEX_LIMITS: rdData_next = joinFields(startIdx_reg, stopIdx_reg);
                        `OFF_BEGIN_TIME:   rdData_next = beginTime_reg;
                        `OFF_CONTROL:      rdData_next = {15'h0000, wren_reg};
                        default:           rdData_next = '0;
                    endcase
                end
                default:
                    rdData_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdData_reg <= 16'h0000;
        else
            rdData_reg <= rdData_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign regRdData           = rdData_reg;
    assign gainRampWriteEnable = wren_reg;
    assign startGain           = startGain_reg;
    assign stopGain            = stopGain_reg;
    assign upStep              = upStep_reg;
    assign profile0DownStep    = downStep_reg;
    assign startIndex          = startIdx_reg;
    assign stopIndex           = stopIdx_reg;
    assign beginTime           = beginTime_reg;
endmodule

// file: src/gain_step_memory.sv
// gain step memory: flip-flop words with no reset
`timescale 1ns/1ps
module gain_step_memory
    import gain_ramp_pkg::*;
#(
    parameter int DEPTH = 160,
    parameter int AW    = 8
)
(
    input  wire logic          sys_clk,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrIdx,
    input  wire word_t         wrData,
    input  wire logic [AW-1:0] rdIdx,
    output word_t              rdData
);
    initial
    begin
        if (DEPTH < 1 || DEPTH >= (1 << AW))
            $error("gain_step_memory: depth does not fit index width");
    end

    word_t memReg [DEPTH];

    // no reset: contents survive reset, undefined at power up
    always_ff @(posedge sys_clk)
    begin
        if (wrEn && (wrIdx < AW'(DEPTH)))
            memReg[wrIdx] <= wrData;
    end

    assign rdData = (rdIdx < AW'(DEPTH)) ? memReg[rdIdx] : '0;
endmodule

// file: verification/gain_ramp_profile_regs_assertions.sv
// checker for the gain ramp profile bank ports
`timescale 1ns/1ps
module gain_ramp_profile_regs_assertions
    import gain_ramp_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic              sys_clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire word_t             regWrData,
    input wire logic              regWrStb,
    input wire logic              regRdStb,
    input wire word_t             regRdData,
    input wire logic              gainRampWriteEnable,
    input wire logic [7:0]        startGain,
    input wire logic [7:0]        stopGain,
    input wire logic [7:0]        upStep,
    input wire logic [7:0]        profile0DownStep,
    input wire logic [7:0]        startIndex,
    input wire logic [7:0]        stopIndex,
    input wire word_t             beginTime
);
// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!arst_n);
sequence s_wr(logic [7:0] a);
    regWrStb && regAddr == a && gainRampWriteEnable;
endsequence
property p_wrLimits;
    s_wr(8'ha1) |=> {startGain, stopGain} == $past(regWrData);
endproperty
property p_wrSteps;
    s_wr(8'ha2) |=> {upStep, profile0DownStep} == $past(regWrData);
endproperty
property p_wrIndex;
    s_wr(8'ha3) |=> {startIndex, stopIndex} == $past(regWrData);
endproperty
property p_wrTime;
    s_wr(8'ha4) |=> beginTime == $past(regWrData);
endproperty
property p_gated;
    regWrStb && !gainRampWriteEnable && regAddr != 8'hf0 |=>
        $stable({startGain, stopGain, upStep, profile0DownStep, startIndex, stopIndex, beginTime});
endproperty
property p_enable;
    regWrStb && regAddr == 8'hf0 |=> gainRampWriteEnable == $past(regWrData[0]);
endproperty
property p_rdLimits;
    regRdStb && regAddr == 8'ha1 |=> regRdData == {$past(startGain), $past(stopGain)};
endproperty
property p_rdTime;
    regRdStb && regAddr == 8'ha4 |=> regRdData == $past(beginTime);
endproperty
property p_rdIdle;
    !$past(regRdStb) |-> regRdData == 16'h0000;
endproperty
property p_rdQuiet;
    regRdStb && !regWrStb |=>
        $stable({gainRampWriteEnable, startGain, stopGain, upStep, profile0DownStep,
                 startIndex, stopIndex, beginTime});
endproperty
a_wrLimits: assert property (p_wrLimits) else $error("start/stop gain write lost");
a_wrSteps: assert property (p_wrSteps) else $error("step write lost");
a_wrIndex: assert property (p_wrIndex) else $error("index write lost");
a_wrTime: assert property (p_wrTime) else $error("begin time write lost");
a_gated: assert property (p_gated) else $error("write took effect while disabled");
a_enable: assert property (p_enable) else $error("enable bit not updated");
a_rdLimits: assert property (p_rdLimits) else $error("read of gain limits wrong");
a_rdTime: assert property (p_rdTime) else $error("read of begin time wrong");
a_rdIdle: assert property (p_rdIdle) else $error("read data not zero when idle");
a_rdQuiet: assert property (p_rdQuiet) else $error("read changed a field");
c_wr: cover property (s_wr(8'ha1));
c_mem: cover property (regRdStb && regAddr == 8'h01);
c_gated: cover property (regWrStb && !gainRampWriteEnable);
endmodule
bind gain_ramp_profile_regs gain_ramp_profile_regs_assertions #(.ADDR_W(ADDR_W))
    gain_ramp_profile_regs_assertions_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .gainRampWriteEnable(gainRampWriteEnable),
    .startGain(startGain), .stopGain(stopGain), .upStep(upStep),
    .profile0DownStep(profile0DownStep), .startIndex(startIndex), .stopIndex(stopIndex),
    .beginTime(beginTime));

// file: verification/gain_ramp_profile_regs_bench.sv
// testbench for the gain ramp profile bank
`timescale 1ns/1ps
module gain_ramp_profile_regs_bench
    import gain_ramp_pkg::*;
;
logic       sys_clk, arst_n, regWrStb, regRdStb, gainRampWriteEnable;
logic [7:0] regAddr, startGain, stopGain, upStep, profile0DownStep, startIndex, stopIndex;
word_t      regWrData, regRdData, beginTime;
int         failCount = 0;
int         comparisons = 0;
logic [7:0] regA [4] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4};
word_t      rstV [4] = '{16'h009f, 16'h00ff, 16'h009f, 16'h0000};
word_t      patV [4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
logic [7:0] badA [5] = '{8'h00, 8'ha5, 8'hef, 8'hf1, 8'hff};
gain_ramp_profile_regs gain_ramp_profile_regs_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .gainRampWriteEnable(gainRampWriteEnable),
    .startGain(startGain), .stopGain(stopGain), .upStep(upStep),
    .profile0DownStep(profile0DownStep), .startIndex(startIndex), .stopIndex(stopIndex),
    .beginTime(beginTime));
// ----------------------------------------
// tasks
// ----------------------------------------
task automatic wrap_up;
    if (failCount == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task automatic check16(input word_t got, input word_t exp);
    comparisons++;
    if (got !== exp)
    begin
        failCount++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input word_t d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
    @(posedge sys_clk);
endtask
task automatic rd(input logic [7:0] a, input word_t exp);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 check16(regRdData, exp);
    @(posedge sys_clk);
endtask
task automatic fields(input word_t v [4]);
    check16({startGain, stopGain}, v[0]);
    check16({upStep, profile0DownStep}, v[1]);
    check16({startIndex, stopIndex}, v[2]);
    check16(beginTime, v[3]);
endtask
task automatic memCheck;
    for (int i = 0; i < 160; i++)
        rd(8'(i + 1), 16'h5a00 + 16'(i));
endtask
// ----------------------------------------
// stimulus
// ----------------------------------------
initial
begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
end
initial
begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    wrap_up();
end
initial
begin
    arst_n <= 1'b0;
    regAddr <= 8'h00;
    regWrData <= 16'h0000;
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    repeat (8) @(posedge sys_clk);
    fields(rstV);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
        wr(regA[i], ~rstV[i]);
    for (int i = 0; i < 4; i++)
        rd(regA[i], rstV[i]);
    wr(8'hf0, 16'hffff);
    check16({15'h0000, gainRampWriteEnable}, 16'h0001);
    rd(8'hf0, 16'h0001);
    for (int i = 0; i < 4; i++)
        wr(regA[i], patV[i]);
    for (int i = 0; i < 4; i++)
        rd(regA[i], patV[i]);
    fields(patV);
    for (int i = 0; i < 160; i++)
        wr(8'(i + 1), 16'h5a00 + 16'(i));
    memCheck();
    wr(8'hf0, 16'h0000);
    check16({15'h0000, gainRampWriteEnable}, 16'h0000);
    wr(8'h01, 16'hdead);
    wr(8'ha0, 16'hbeef);
    wr(8'ha1, 16'h0000);
    rd(8'h01, 16'h5a00);
    rd(8'ha0, 16'h5a9f);
    rd(8'ha1, 16'h1234);
    // unmapped addresses with writes enabled
    wr(8'hf0, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
        wr(badA[i], 16'h0000);
        rd(badA[i], 16'h0000);
    end
    rd(8'hf0, 16'h0001);
    fields(patV);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    fields(rstV);
    rd(8'hf0, 16'h0000);
    memCheck();
    wrap_up();
end
endmodule
